// ---- verilog/scpc_pkg.sv ----
package scpc_pkg;
  // register byte addresses
  localparam logic [7:0] SCPC_ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] SCPC_ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] SCPC_ADDR_IEN0 = 8'h08;
  localparam logic [7:0] SCPC_ADDR_IST0 = 8'h0c;
  localparam logic [7:0] SCPC_ADDR_STAT0 = 8'h10;
  localparam logic [7:0] SCPC_ADDR_STAT1 = 8'h14;
  localparam logic [7:0] SCPC_ADDR_TEST4 = 8'h18;
  localparam logic [7:0] SCPC_ADDR_DMA_STATUS = 8'h1c;
  localparam logic [7:0] SCPC_ADDR_DMA_IRQ_ENABLE = 8'h20;
  localparam logic [7:0] SCPC_ADDR_SCSI_INPUT_DATA_LATCH = 8'h24;
  localparam logic [7:0] SCPC_ADDR_HALT = 8'h28;

  // field positions
  localparam int SCPC_BIT_ATN_ON_ERR = 1;
  localparam int SCPC_BIT_CHECK_EN = 3;
  localparam int SCPC_BIT_EVEN_SEND = 2;
  localparam int SCPC_BIT_HALT_DIS = 5;
  localparam int SCPC_BIT_PAR_IRQ = 0;
  localparam int SCPC_BIT_LIVE_PAR = 0;
  localparam int SCPC_BIT_LATCH_PAR = 3;
  localparam int SCPC_BIT_MPAR_EN = 3;
  localparam int SCPC_BIT_MPAR_ERR = 6;
  localparam int SCPC_BIT_RESUME = 0;
  localparam int SCPC_BIT_PENDING = 1;

  // reset values
  localparam logic [7:0] SCPC_RST_BYTE = 8'h00;
  localparam logic [31:0] SCPC_RST_WORD = 32'h0000_0000;

  // halt engine states
  typedef enum logic [1:0] {
    SCPC_RUN,
    SCPC_DEFER,
    SCPC_HALTED
  } scpc_halt_t;
endpackage

// ---- verilog/scpc_core.sv ----
`timescale 1ns/10ps
// Operation
// - initiator error auto-asserts attention when enabled
// - check enable turns odd receive checking on
// - even-sense bit picks send parity polarity
// - parity always generated; receive check stays odd
// - even send allows deliberate bad parity
// - halt-disable only acts in target mode
// - halt-disable clear: halt in both modes
// - halt-disable set: target halts at transfer end
// - irq enable gates parity error interrupt
// - status bit set on every receive error
// - checking off: no error, no reaction
// - status bit shows live parity line
// - status bit holds latched byte odd parity
// - master parity enable turns on data checking
// - target-signalled error sets master status bit
// - master irq enable gates irq, status still set
module scpc_core (
  // clock and asynchronous chip reset
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // register bus, zero wait states
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // role on the scsi bus: high while acting as target
  input wire logic target_mode_in,
  // receive side: byte, parity line and latch strobe
  input wire logic [7:0] scsi_data_in,
  input wire logic scsi_data_parity_line_in,
  input wire logic rx_latch_in,
  // send side: byte and load strobe, byte plus parity out
  input wire logic [7:0] tx_data_in,
  input wire logic tx_load_in,
  output logic [7:0] scsi_data_out,
  output logic scsi_parity_out,
  // end of the current transfer, used by the deferred halt
  input wire logic transfer_end_in,
  // host bus master data phase and the target's error report
  input wire logic pci_data_phase_in,
  input wire logic pci_perr_in,
  // reactions towards the scsi core and the host
  output logic atn_assert_out,
  output logic halt_out,
  output logic irq_out
);
  import scpc_pkg::*;

  // software visible byte registers; each sits in the low byte of a
  // word, upper bits read as zero and are ignored on writes
  logic [7:0] scsi_control_zero;
  logic [7:0] scsi_control_one;
  logic [7:0] scsi_irq_enable_zero;
  logic [7:0] scsi_irq_status_zero;
  logic [7:0] chip_test_four;
  logic [7:0] dma_status;
  logic [7:0] dma_irq_enable;
  logic [7:0] scsi_input_data_latch;
  logic latched_parity;
  // halt engine: run, waiting for transfer end, or stopped
  scpc_halt_t halt_state;
  scpc_halt_t next_halt_state;

  // bus decode and derived control levels
  logic setup;
  logic access;
  logic wr_access;
  logic rd_access;
  logic check_en;
  logic even_send;
  logic halt_dis;
  logic rx_error;
  logic mpar_error;
  logic resume;
  logic rd_ist0;
  logic rd_dma_status;
  logic hit;
  logic [31:0] next_rdata;

  // bus phases; writes and read side effects happen at the access edge.
  // clearing on read only in the access phase keeps an aborted setup
  // from losing a pending status bit.
  assign setup = psel_in & ~penable_in;
  assign access = psel_in & penable_in;
  assign wr_access = access & pwrite_in;
  assign rd_access = access & ~pwrite_in;
  assign rd_ist0 = rd_access & (paddr_in == SCPC_ADDR_IST0);
  assign rd_dma_status = rd_access & (paddr_in == SCPC_ADDR_DMA_STATUS);
  assign resume = wr_access & (paddr_in == SCPC_ADDR_HALT) &
                  pwdata_in[SCPC_BIT_RESUME];
  // read data is staged in setup, so access never waits; the trade is
  // that live inputs are seen one cycle before the access edge
  assign pready_out = penable_in;

  // control fields pulled out once so the logic below reads plainly
  assign check_en = scsi_control_zero[SCPC_BIT_CHECK_EN];
  assign even_send = scsi_control_one[SCPC_BIT_EVEN_SEND];
  assign halt_dis = scsi_control_one[SCPC_BIT_HALT_DIS];

  // odd check over data plus parity line; off means no detection at all.
  // checking stays odd whatever the send sense is, so a looped back
  // even byte shows up here as an error on purpose.
  // the check is only made in the cycle the byte is latched; a line
  // that moves between strobes is never judged.
  assign rx_error = rx_latch_in & check_en &
                    ~(^{scsi_data_in, scsi_data_parity_line_in});
  assign mpar_error = chip_test_four[SCPC_BIT_MPAR_EN] &
                      pci_data_phase_in & pci_perr_in;

  // master side: only a reported error during an enabled data phase
  // counts; the enable gates detection, not just the interrupt

  // software control registers; unmapped writes are dropped and the
  // bus is told through the error response staged in setup
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scsi_control_zero <= SCPC_RST_BYTE;
      scsi_control_one <= SCPC_RST_BYTE;
      scsi_irq_enable_zero <= SCPC_RST_BYTE;
      chip_test_four <= SCPC_RST_BYTE;
      dma_irq_enable <= SCPC_RST_BYTE;
    end else if (wr_access) begin
      case (paddr_in)
        SCPC_ADDR_CTRL0: scsi_control_zero <= pwdata_in[7:0];
        SCPC_ADDR_CTRL1: scsi_control_one <= pwdata_in[7:0];
        SCPC_ADDR_IEN0: scsi_irq_enable_zero <= pwdata_in[7:0];
        SCPC_ADDR_TEST4: chip_test_four <= pwdata_in[7:0];
        SCPC_ADDR_DMA_IRQ_ENABLE: dma_irq_enable <= pwdata_in[7:0];
        default: begin
        end
      endcase
    end
  end

  // sticky scsi error status; a new error beats the read clear.
  // set whatever the interrupt enable says, so polling still works.
  // the whole byte clears on read, matching the other status bits
  // that later versions may add to it.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scsi_irq_status_zero <= SCPC_RST_BYTE;
    end else if (rx_error) begin
      scsi_irq_status_zero[SCPC_BIT_PAR_IRQ] <= 1'b1;
    end else if (rd_ist0) begin
      scsi_irq_status_zero <= SCPC_RST_BYTE;
    end
  end

  // sticky master parity status, set regardless of its irq enable.
  // as above, an error landing on the clearing read is not lost.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dma_status <= SCPC_RST_BYTE;
    end else if (mpar_error) begin
      dma_status[SCPC_BIT_MPAR_ERR] <= 1'b1;
    end else if (rd_dma_status) begin
      dma_status <= SCPC_RST_BYTE;
    end
  end

  // input latch and the odd parity that belongs to its byte.
  // the latched parity is computed from the data, not copied from the
  // line, so software can compare it with the live bit to spot errors.
  // latched even with checking off; only detection is switched.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scsi_input_data_latch <= SCPC_RST_BYTE;
      latched_parity <= 1'b1;
    end else if (rx_latch_in) begin
      scsi_input_data_latch <= scsi_data_in;
      latched_parity <= ~(^scsi_data_in);
    end
  end

  // send path: parity is produced on every byte whatever checking says;
  // even sense against an odd receiver is how bad parity is forced
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scsi_data_out <= SCPC_RST_BYTE;
      scsi_parity_out <= 1'b1;
    end else if (tx_load_in) begin
      scsi_data_out <= tx_data_in;
      scsi_parity_out <= even_send ? (^tx_data_in) : ~(^tx_data_in);
    end
  end

  // halt decision; initiator ignores halt-disable.
  // in target mode with halting disabled the error is remembered in
  // the defer state and the stop comes when the transfer ends; an end
  // in the same cycle as the error stops at once.
  // once stopped only a resume write restarts the engine; a further
  // error while stopped changes nothing.
  always_comb begin
    next_halt_state = halt_state;
    case (halt_state)
      SCPC_RUN: begin
        if (rx_error) begin
          if (halt_dis && target_mode_in) begin
            next_halt_state = transfer_end_in ? SCPC_HALTED : SCPC_DEFER;
          end else begin
            next_halt_state = SCPC_HALTED;
          end
        end
      end
      SCPC_DEFER: begin
        if (transfer_end_in) begin
          next_halt_state = SCPC_HALTED;
        end
      end
      SCPC_HALTED: begin
        if (resume) begin
          next_halt_state = SCPC_RUN;
        end
      end
      default: next_halt_state = SCPC_RUN;
    endcase
  end

  // state register for the halt engine
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      halt_state <= SCPC_RUN;
    end else begin
      halt_state <= next_halt_state;
    end
  end

  // registered so the core sees a clean level; taken from the next
  // state so the output lines up with the state register
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      halt_out <= 1'b0;
    end else begin
      halt_out <= (next_halt_state == SCPC_HALTED);
    end
  end

  // attention held until software resumes or drops the enable.
  // only an initiator may ask for attention; a target error never
  // raises it. a new error wins over a clear in the same cycle.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      atn_assert_out <= 1'b0;
    end else if (rx_error && !target_mode_in &&
                 scsi_control_zero[SCPC_BIT_ATN_ON_ERR]) begin
      atn_assert_out <= 1'b1;
    end else if (resume || !scsi_control_zero[SCPC_BIT_ATN_ON_ERR]) begin
      atn_assert_out <= 1'b0;
    end
  end

  // level interrupt: any unmasked sticky bit.
  // registered, so it follows a status change by one cycle; masking
  // a bit drops the request without touching the status.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= (|(scsi_irq_status_zero & scsi_irq_enable_zero)) |
                 (|(dma_status & dma_irq_enable));
    end
  end

  // read mux, sampled during setup.
  // status and halt fields are decoded here so a read always returns
  // the state as it stood one cycle before the access edge.
  // unmapped offsets read zero and flag an error response.
  always_comb begin
    next_rdata = SCPC_RST_WORD;
    hit = 1'b1;
    case (paddr_in)
      SCPC_ADDR_CTRL0: next_rdata[7:0] = scsi_control_zero;
      SCPC_ADDR_CTRL1: next_rdata[7:0] = scsi_control_one;
      SCPC_ADDR_IEN0: next_rdata[7:0] = scsi_irq_enable_zero;
      SCPC_ADDR_IST0: next_rdata[7:0] = scsi_irq_status_zero;
      SCPC_ADDR_STAT0:
        next_rdata[SCPC_BIT_LIVE_PAR] = scsi_data_parity_line_in;
      SCPC_ADDR_STAT1: next_rdata[SCPC_BIT_LATCH_PAR] = latched_parity;
      SCPC_ADDR_TEST4: next_rdata[7:0] = chip_test_four;
      SCPC_ADDR_DMA_STATUS: next_rdata[7:0] = dma_status;
      SCPC_ADDR_DMA_IRQ_ENABLE: next_rdata[7:0] = dma_irq_enable;
      SCPC_ADDR_SCSI_INPUT_DATA_LATCH: next_rdata[7:0] = scsi_input_data_latch;
      SCPC_ADDR_HALT: begin
        next_rdata[SCPC_BIT_RESUME] = (halt_state == SCPC_HALTED);
        next_rdata[SCPC_BIT_PENDING] = (halt_state == SCPC_DEFER);
      end
      default: hit = 1'b0;
    endcase
  end

  // live parity bit is a snapshot from the setup cycle; a user that
  // needs the exact level must hold the line through the read.
  // write data never loops back into the read register.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prdata_out <= SCPC_RST_WORD;
      pslverr_out <= 1'b0;
    end else if (setup) begin
      prdata_out <= pwrite_in ? SCPC_RST_WORD : next_rdata;
      pslverr_out <= ~hit;
    end
  end
endmodule // scpc_core

// ---- tb/scpc_assertions.sv ----
`timescale 1ns/10ps
module scpc_assertions (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic pready_out,
  input wire logic tx_load_in,
  input wire logic [7:0] tx_data_in,
  input wire logic [7:0] scsi_data_out,
  input wire logic rx_latch_in,
  input wire logic target_mode_in,
  input wire logic transfer_end_in,
  input wire logic pci_data_phase_in,
  input wire logic halt_out,
  input wire logic atn_assert_out,
  input wire logic irq_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  a_tx_byte_load: assert property (tx_load_in |=>
    scsi_data_out == $past(tx_data_in)) else $error("sent byte");
  a_tx_byte_hold: assert property (!tx_load_in |=>
    $stable(scsi_data_out)) else $error("sent byte moved");
  a_halt_cause: assert property ($rose(halt_out) |->
    $past(rx_latch_in) || $past(transfer_end_in)) else $error("halt");
  a_atn_cause: assert property ($rose(atn_assert_out) |->
    $past(rx_latch_in) && !$past(target_mode_in)) else $error("atn");
  a_irq_cause: assert property ($rose(irq_out) |->
    $past(rx_latch_in, 2) || $past(pci_data_phase_in, 2) ||
    $past(pci_data_phase_in) || $past(penable_in)) else $error("irq");
  a_halt_sticky: assert property (halt_out && !pwrite_in |=>
    halt_out) else $error("halt dropped");
  a_atn_sticky: assert property (atn_assert_out && !pwrite_in |=>
    atn_assert_out) else $error("atn dropped");
  a_apb_ready: assert property (psel_in && penable_in |->
    pready_out) else $error("no ready");
  c_halt: cover property ($rose(halt_out));
  c_atn: cover property ($rose(atn_assert_out));
  c_irq: cover property ($rose(irq_out));
  c_defer: cover property (target_mode_in && transfer_end_in ##1 halt_out);
endmodule // scpc_assertions

bind scpc_core scpc_assertions i_scpc_assertions (.*);

// ---- tb/scpc_scsi_peer.sv ----
`timescale 1ns/10ps
module scpc_scsi_peer (
  input wire logic clk_in,
  output logic [7:0] data_out,
  output logic par_out,
  output logic latch_out
);
  // idle bus before any frame
  initial begin
    data_out = 8'h00;
    par_out = 1'b1;
    latch_out = 1'b0;
  end
  // one byte; bad flips the odd parity bit for error tests
  task automatic send_byte(input logic [7:0] d, input logic bad);
    data_out <= d;
    par_out <= ~^d ^ bad;
    latch_out <= 1'b1;
    @(posedge clk_in);
    latch_out <= 1'b0;
    // released lines invert so a stale byte after a good one never looks valid
    data_out <= ~d;
    par_out <= ^d ^ bad;
  endtask
endmodule // scpc_scsi_peer

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  import scpc_pkg::*;
  logic ref_clk_in = 1'b0;
  logic arst_n_in, psel_in, penable_in, pwrite_in, pready_out;
  logic pslverr_out, serr, target_mode_in, scsi_data_parity_line_in;
  logic rx_latch_in, tx_load_in, transfer_end_in, pci_data_phase_in;
  logic pci_perr_in, atn_assert_out, halt_out, irq_out, scsi_parity_out;
  logic [7:0] paddr_in, tx_data_in, scsi_data_in, scsi_data_out;
  logic [31:0] pwdata_in, prdata_out, rdat;
  int fail_count = 0;
  int n_tests = 0;
  // 50 MHz
  always #10 ref_clk_in = ~ref_clk_in;
  scpc_core i_scpc_core (.*);
  scpc_scsi_peer i_scpc_scsi_peer (.clk_in(ref_clk_in),
    .data_out(scsi_data_in), .par_out(scsi_data_parity_line_in),
    .latch_out(rx_latch_in));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  // apb transfer; ends with an idle edge so calls chain safely
  task automatic ab(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 16);
    if (pready_out !== 1'b1) begin
      fail_count++;
      $display("ERROR %0t no pready", $time);
      wrap_up();
    end
    rdat = prdata_out;
    serr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ab(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic pci();
    pci_data_phase_in <= 1'b1;
    pci_perr_in <= 1'b1;
    @(posedge ref_clk_in);
    pci_data_phase_in <= 1'b0;
    pci_perr_in <= 1'b0;
    tick(2);
  endtask
  task automatic wrap_up();
    $display("tests %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial begin
    {arst_n_in, psel_in, penable_in, pwrite_in, target_mode_in} = '0;
    {tx_load_in, transfer_end_in, pci_data_phase_in, pci_perr_in} = '0;
    {paddr_in, tx_data_in, pwdata_in} = '0;
    tick(6);
    arst_n_in <= 1'b1;
    @(posedge ref_clk_in);
    chk(32'(scsi_parity_out), 32'h1);
    for (int e = 0; e < 2; e++) begin
      ab(1'b1, SCPC_ADDR_CTRL1, e ? 32'h4 : 32'h0);
      tx_data_in <= 8'h01;
      tx_load_in <= 1'b1;
      @(posedge ref_clk_in);
      tx_load_in <= 1'b0;
      @(posedge ref_clk_in);
      chk(32'(scsi_parity_out), e ? 32'h1 : 32'h0);
      chk(32'(scsi_data_out), 32'h1);
    end
    i_scpc_scsi_peer.send_byte(8'h00, 1'b1);
    tick(2);
    rd(SCPC_ADDR_IST0, 32'h0);
    ab(1'b1, SCPC_ADDR_CTRL1, 32'h0);
    ab(1'b1, SCPC_ADDR_CTRL0, 32'h0a);
    ab(1'b1, SCPC_ADDR_IEN0, 32'h1);
    i_scpc_scsi_peer.send_byte(8'h5a, 1'b0);
    tick(2);
    chk(32'(halt_out), 32'h0);
    i_scpc_scsi_peer.send_byte(8'h03, 1'b1);
    tick(2);
    chk(32'(atn_assert_out), 32'h1);
    chk(32'(halt_out), 32'h1);
    chk(32'(irq_out), 32'h1);
    rd(SCPC_ADDR_SCSI_INPUT_DATA_LATCH, 32'h3);
    rd(SCPC_ADDR_STAT1, 32'h8);
    rd(SCPC_ADDR_STAT0, 32'h1);
    rd(SCPC_ADDR_IST0, 32'h1);
    tick(1);
    chk(32'(irq_out), 32'h0);
    ab(1'b1, SCPC_ADDR_HALT, 32'h1);
    chk(32'(halt_out), 32'h0);
    // target mode, halt deferred, interrupt masked
    ab(1'b1, SCPC_ADDR_CTRL1, 32'h20);
    ab(1'b1, SCPC_ADDR_IEN0, 32'h0);
    target_mode_in <= 1'b1;
    i_scpc_scsi_peer.send_byte(8'h03, 1'b1);
    tick(2);
    chk(32'(halt_out), 32'h0);
    chk(32'(irq_out), 32'h0);
    rd(SCPC_ADDR_HALT, 32'h2);
    transfer_end_in <= 1'b1;
    @(posedge ref_clk_in);
    transfer_end_in <= 1'b0;
    tick(2);
    chk(32'(halt_out), 32'h1);
    rd(SCPC_ADDR_IST0, 32'h1);
    ab(1'b1, SCPC_ADDR_DMA_IRQ_ENABLE, 32'h40);
    pci();
    rd(SCPC_ADDR_DMA_STATUS, 32'h0);
    ab(1'b1, SCPC_ADDR_TEST4, 32'h8);
    pci();
    chk(32'(irq_out), 32'h1);
    rd(SCPC_ADDR_DMA_STATUS, 32'h40);
    ab(1'b1, SCPC_ADDR_DMA_IRQ_ENABLE, 32'h0);
    pci();
    chk(32'(irq_out), 32'h0);
    rd(SCPC_ADDR_DMA_STATUS, 32'h40);
    ab(1'b0, 8'h3c, 32'h0);
    chk(32'(serr), 32'h1);
    chk(rdat, 32'h0);
    wrap_up();
  end
endmodule // tb_top
